// ### rtl/timer_capture_compare_unit.sv
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
// Function
// - Capture source is pin or comparator flag.
// - Active edge copies counter, sets capture flag.
// - Captured value is counter plus one.
// - Counter advances once per four clocks.
// - Reset keeps capture register contents.
// - Capture high read blocks captures until low.
// - Capture flag clears: status read, capture low.
// - Capture pair holds most recent capture.
// - Every fourth clock compare, drive level on match.
// - Compare pair read/write, kept over reset.
// - Compare high write disables matching until low.
// - Compare flag clears: status read, compare low.
// - Match loads output latch regardless of flag.
// - Reset clears control except edge select.
// - Three enables gate capture, compare, overflow interrupts.
// - Edge select picks rising or falling edge.
// - Output level bit sets pin high/low.
// - Status writes ignored, flags kept over reset.
// - Compare flag set when counter equals compare.
// - Overflow flag on wrap, cleared via counter low.
// - Reset presets counter to three below max.
// - Counter high read freezes counter low byte.
module timer_capture_compare_unit #(
  parameter int ADDR_WIDTH = 8
) (
  input wire logic I_CLK_SYS,
  input wire logic I_NRST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [ADDR_WIDTH-1:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic I_CAPTURE_INPUT_PIN,
  input wire logic I_COMPARATOR_TWO_FLAG,
  output logic O_COMPARE_OUTPUT_PIN,
  output logic O_TIMER_IRQ
);

  // ****************************************************************
  // Address decoding.
  // ****************************************************************
  function automatic logic hits(input logic [ADDR_WIDTH-1:0] addr, input logic [5:0] idx);
    hits = (addr[ADDR_WIDTH-1:2] == {{(ADDR_WIDTH-8){1'b0}}, idx}) && (addr[1:0] == 2'h0);
  endfunction : hits

  wire setup_phase = I_PSEL & ~I_PENABLE;
  wire access_phase = I_PSEL & I_PENABLE;
  wire rd = access_phase & ~I_PWRITE;
  wire wr = access_phase & I_PWRITE;

  wire sel_control = hits(I_PADDR, tcc_pkg::IDX_TIMER_CONTROL);
  wire sel_flags = hits(I_PADDR, tcc_pkg::IDX_TIMER_FLAGS);
  wire sel_cap_hi = hits(I_PADDR, tcc_pkg::IDX_CAPTURE_HIGH);
  wire sel_cap_lo = hits(I_PADDR, tcc_pkg::IDX_CAPTURE_LOW);
  wire sel_cmp_hi = hits(I_PADDR, tcc_pkg::IDX_COMPARE_HIGH);
  wire sel_cmp_lo = hits(I_PADDR, tcc_pkg::IDX_COMPARE_LOW);
  wire sel_cnt_hi = hits(I_PADDR, tcc_pkg::IDX_COUNTER_HIGH);
  wire sel_cnt_lo = hits(I_PADDR, tcc_pkg::IDX_COUNTER_LOW);
  wire sel_analog = hits(I_PADDR, tcc_pkg::IDX_ANALOG_CONTROL);
  wire mapped = sel_control | sel_flags | sel_cap_hi | sel_cap_lo | sel_cmp_hi | sel_cmp_lo
    | sel_cnt_hi | sel_cnt_lo | sel_analog;

  // ****************************************************************
  // State.
  // ****************************************************************
  // Registers that reset must leave alone carry no reset term; the
  // declaration value stands for their power-up state.
  logic [15:0] capture = 16'h0000;
  logic [15:0] compare = 16'h0000;
  logic capture_flag = 1'b0;
  logic compare_flag = 1'b0;
  logic overflow_flag = 1'b0;
  logic capture_edge_select = 1'b0;

  logic capture_irq_enable;
  logic compare_irq_enable;
  logic overflow_irq_enable;
  logic compare_output_level;
  logic capture_source_select;
  logic [1:0] prescale;
  logic [15:0] counter;
  logic pin_meta;
  logic pin_sync;
  logic source_prev;
  logic [2:0] settle;
  logic capture_blocked;
  logic compare_blocked;
  logic low_frozen;
  logic [7:0] low_buffer;
  logic arm_capture;
  logic arm_compare;
  logic arm_overflow;
  logic output_latch;
  logic [31:0] read_data;

  // ****************************************************************
  // Prescaler and free-running counter.
  // ****************************************************************
  wire tick = (prescale == tcc_pkg::PRESCALE_LAST);
  wire wrap = tick & (counter == tcc_pkg::COUNTER_MAX);
  wire [15:0] next_counter = counter + 16'h0001;

  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      prescale <= 2'h0;
      counter <= tcc_pkg::COUNTER_RESET;
    end else begin
      prescale <= prescale + 2'h1;
      if (tick) begin
        counter <= next_counter;
      end
    end
  end

  // ****************************************************************
  // Capture source and edge detection.
  // ****************************************************************
  // The comparator flag comes from logic on this clock and needs no
  // synchroniser. Switching the source may fake one edge; software
  // should re-read the flags after changing the source.
  wire capture_source = capture_source_select ? I_COMPARATOR_TWO_FLAG : pin_sync;

  // Edges are ignored until the synchroniser and the previous-value flop
  // hold real samples, so a pin held high across reset is not an edge.
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      source_prev <= 1'b0;
      settle <= 3'h0;
    end else begin
      pin_meta <= I_CAPTURE_INPUT_PIN;
      pin_sync <= pin_meta;
      source_prev <= capture_source;
      settle <= {settle[1:0], 1'b1};
    end
  end

  wire rise = capture_source & ~source_prev;
  wire fall = ~capture_source & source_prev;
  wire active_edge = capture_edge_select ? rise : fall;
  wire capture_take = active_edge & settle[2] & ~capture_blocked;

  // The counter value is one behind the pin by the synchroniser delay.
  wire [15:0] capture_value = next_counter;

  always_ff @(posedge I_CLK_SYS) begin
    if (capture_take) begin
      capture <= capture_value;
    end
  end

  // ****************************************************************
  // Compare.
  // ****************************************************************
  wire compare_match = tick & ~compare_blocked & (counter == compare);

  always_ff @(posedge I_CLK_SYS) begin
    if (wr && sel_cmp_hi) begin
      compare[15:8] <= I_PWDATA[7:0];
    end
    if (wr && sel_cmp_lo) begin
      compare[7:0] <= I_PWDATA[7:0];
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      output_latch <= 1'b0;
    end else if (compare_match) begin
      output_latch <= compare_output_level;
    end
  end

  // ****************************************************************
  // Access sequencing: blocks, low byte buffer and flag arming.
  // ****************************************************************
  wire access_cap_lo = rd & sel_cap_lo;
  wire access_cmp_lo = access_phase & sel_cmp_lo;
  wire access_cnt_lo = access_phase & sel_cnt_lo;
  wire read_flags = rd & sel_flags;

  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      capture_blocked <= 1'b0;
      compare_blocked <= 1'b0;
    end else begin
      if (rd && sel_cap_hi) begin
        capture_blocked <= 1'b1;
      end else if (access_cap_lo) begin
        capture_blocked <= 1'b0;
      end
      if (wr && sel_cmp_hi) begin
        compare_blocked <= 1'b1;
      end else if (wr && sel_cmp_lo) begin
        compare_blocked <= 1'b0;
      end
    end
  end

  // Repeated high reads keep the first frozen value.
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      low_frozen <= 1'b0;
      low_buffer <= 8'h00;
    end else if (rd && sel_cnt_hi && !low_frozen) begin
      low_frozen <= 1'b1;
      low_buffer <= counter[7:0];
    end else if (rd && sel_cnt_lo) begin
      low_frozen <= 1'b0;
    end
  end

  // An arm is taken from the flag as it stands at the status read, so a
  // flag set afterwards is not cleared by the following low access.
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      arm_capture <= 1'b0;
      arm_compare <= 1'b0;
      arm_overflow <= 1'b0;
    end else begin
      if (read_flags) begin
        arm_capture <= capture_flag;
        arm_compare <= compare_flag;
        arm_overflow <= overflow_flag;
      end else begin
        if (access_cap_lo) begin
          arm_capture <= 1'b0;
        end
        if (access_cmp_lo) begin
          arm_compare <= 1'b0;
        end
        if (access_cnt_lo) begin
          arm_overflow <= 1'b0;
        end
      end
    end
  end

  // ****************************************************************
  // Status flags; a new event wins over a clear in the same cycle.
  // ****************************************************************
  wire clear_capture = access_cap_lo & arm_capture;
  wire clear_compare = access_cmp_lo & arm_compare;
  wire clear_overflow = access_cnt_lo & arm_overflow;

  always_ff @(posedge I_CLK_SYS) begin
    if (capture_take) begin
      capture_flag <= 1'b1;
    end else if (clear_capture) begin
      capture_flag <= 1'b0;
    end
    if (compare_match) begin
      compare_flag <= 1'b1;
    end else if (clear_compare) begin
      compare_flag <= 1'b0;
    end
    if (wrap) begin
      overflow_flag <= 1'b1;
    end else if (clear_overflow) begin
      overflow_flag <= 1'b0;
    end
  end

  // ****************************************************************
  // Control registers.
  // ****************************************************************
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      capture_irq_enable <= tcc_pkg::CONTROL_RESET[tcc_pkg::CTRL_CAPTURE_IRQ_ENABLE];
      compare_irq_enable <= tcc_pkg::CONTROL_RESET[tcc_pkg::CTRL_COMPARE_IRQ_ENABLE];
      overflow_irq_enable <= tcc_pkg::CONTROL_RESET[tcc_pkg::CTRL_OVERFLOW_IRQ_ENABLE];
      compare_output_level <= tcc_pkg::CONTROL_RESET[tcc_pkg::CTRL_COMPARE_OUTPUT_LEVEL];
      capture_source_select <= 1'b0;
    end else begin
      if (wr && sel_control) begin
        capture_irq_enable <= I_PWDATA[tcc_pkg::CTRL_CAPTURE_IRQ_ENABLE];
        compare_irq_enable <= I_PWDATA[tcc_pkg::CTRL_COMPARE_IRQ_ENABLE];
        overflow_irq_enable <= I_PWDATA[tcc_pkg::CTRL_OVERFLOW_IRQ_ENABLE];
        compare_output_level <= I_PWDATA[tcc_pkg::CTRL_COMPARE_OUTPUT_LEVEL];
      end
      if (wr && sel_analog) begin
        capture_source_select <= I_PWDATA[tcc_pkg::ANALOG_CAPTURE_SOURCE_SELECT];
      end
    end
  end

  // Edge select survives every reset, so it sits outside the reset tree.
  always_ff @(posedge I_CLK_SYS) begin
    if (wr && sel_control) begin
      capture_edge_select <= I_PWDATA[tcc_pkg::CTRL_CAPTURE_EDGE_SELECT];
    end
  end

  // ****************************************************************
  // Read path.
  // ****************************************************************
  wire [7:0] control_byte = {capture_irq_enable, compare_irq_enable, overflow_irq_enable,
    3'h0, capture_edge_select, compare_output_level};
  // Writes to the flags have no decoded effect at all.
  wire [7:0] flags_byte = {capture_flag, compare_flag, overflow_flag, 5'h00};
  wire [7:0] counter_low_view = low_frozen ? low_buffer : counter[7:0];
  wire [7:0] analog_byte = {7'h00, capture_source_select};

  always_comb begin
    read_data = 32'h0000_0000;
    if (sel_control) begin
      read_data = {24'h000000, control_byte};
    end else if (sel_flags) begin
      read_data = {24'h000000, flags_byte};
    end else if (sel_cap_hi) begin
      read_data = {24'h000000, capture[15:8]};
    end else if (sel_cap_lo) begin
      read_data = {24'h000000, capture[7:0]};
    end else if (sel_cmp_hi) begin
      read_data = {24'h000000, compare[15:8]};
    end else if (sel_cmp_lo) begin
      read_data = {24'h000000, compare[7:0]};
    end else if (sel_cnt_hi) begin
      read_data = {24'h000000, counter[15:8]};
    end else if (sel_cnt_lo) begin
      read_data = {24'h000000, counter_low_view};
    end else if (sel_analog) begin
      read_data = {24'h000000, analog_byte};
    end
  end

  // Read data is sampled in the setup cycle so it can stand in a flop
  // with no wait state; side effects happen in the access cycle.
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      O_PRDATA <= 32'h0000_0000;
    end else if (setup_phase && !I_PWRITE) begin
      O_PRDATA <= read_data;
    end
  end

  // ****************************************************************
  // Outputs.
  // ****************************************************************
  assign O_PREADY = 1'b1;
  assign O_PSLVERR = access_phase & ~mapped;
  assign O_COMPARE_OUTPUT_PIN = output_latch;
  assign O_TIMER_IRQ = (capture_flag & capture_irq_enable)
    | (compare_flag & compare_irq_enable)
    | (overflow_flag & overflow_irq_enable);

endmodule : timer_capture_compare_unit

// ### rtl/tcc_pkg.sv
package tcc_pkg;

  // ****************************************************************
  // Register indices; the byte address on the bus is four times these.
  // ****************************************************************
  localparam logic [5:0] IDX_TIMER_CONTROL = 6'h12;
  localparam logic [5:0] IDX_TIMER_FLAGS = 6'h13;
  localparam logic [5:0] IDX_CAPTURE_HIGH = 6'h14;
  localparam logic [5:0] IDX_CAPTURE_LOW = 6'h15;
  localparam logic [5:0] IDX_COMPARE_HIGH = 6'h16;
  localparam logic [5:0] IDX_COMPARE_LOW = 6'h17;
  localparam logic [5:0] IDX_COUNTER_HIGH = 6'h18;
  localparam logic [5:0] IDX_COUNTER_LOW = 6'h19;
  localparam logic [5:0] IDX_ANALOG_CONTROL = 6'h1D;

  // ****************************************************************
  // Field positions.
  // ****************************************************************
  localparam int CTRL_CAPTURE_IRQ_ENABLE = 7;
  localparam int CTRL_COMPARE_IRQ_ENABLE = 6;
  localparam int CTRL_OVERFLOW_IRQ_ENABLE = 5;
  localparam int CTRL_CAPTURE_EDGE_SELECT = 1;
  localparam int CTRL_COMPARE_OUTPUT_LEVEL = 0;
  localparam int FLAG_CAPTURE = 7;
  localparam int FLAG_COMPARE = 6;
  localparam int FLAG_OVERFLOW = 5;
  localparam int ANALOG_CAPTURE_SOURCE_SELECT = 0;

  // ****************************************************************
  // Reset values and timing.
  // ****************************************************************
  localparam logic [15:0] COUNTER_RESET = 16'hFFFC;
  localparam logic [15:0] COUNTER_MAX = 16'hFFFF;
  localparam logic [1:0] PRESCALE_LAST = 2'h3;
  localparam logic [7:0] CONTROL_RESET = 8'h00;

endpackage : tcc_pkg

// ### test/tcc_sva.sv
`timescale 1ns/1ps
// ****************************************************************
// Port checker for the capture/compare timer.
// ****************************************************************
module tcc_sva #(
  parameter int ADDR_WIDTH = 8
) (
  input wire logic I_CLK_SYS,
  input wire logic I_NRST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [ADDR_WIDTH-1:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [31:0] O_PRDATA,
  input wire logic O_PREADY,
  input wire logic O_PSLVERR,
  input wire logic I_CAPTURE_INPUT_PIN,
  input wire logic I_COMPARATOR_TWO_FLAG,
  input wire logic O_COMPARE_OUTPUT_PIN,
  input wire logic O_TIMER_IRQ
);
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_NRST);
  sequence access_s;
    I_PSEL && I_PENABLE;
  endsequence
  sequence ctrl_write_s;
    access_s ##0 (I_PWRITE && I_PADDR == 8'h48);
  endsequence
  ready_high_a: assert property (O_PREADY) else $error("pready low");
  err_phase_a: assert property (O_PSLVERR |-> I_PSEL && I_PENABLE)
    else $error("pslverr outside access");
  unmapped_err_a: assert property (access_s ##0 (I_PADDR == 8'h00) |-> O_PSLVERR)
    else $error("no error on unmapped address");
  mapped_ok_a: assert property (access_s ##0 (I_PADDR == 8'h48) |-> !O_PSLVERR)
    else $error("error on control register");
  upper_zero_a: assert property (O_PRDATA[31:8] == 24'h0) else $error("read data upper bits set");
  irq_gate_a: assert property (ctrl_write_s ##0 (I_PWDATA[7:5] == 3'h0) |=> !O_TIMER_IRQ)
    else $error("irq with all enables off");
  reset_idle_a: assert property ($rose(I_NRST) |-> !O_TIMER_IRQ && !O_COMPARE_OUTPUT_PIN)
    else $error("outputs active after reset");
  pin_hold_a: assert property ($changed(O_COMPARE_OUTPUT_PIN) |=>
    $stable(O_COMPARE_OUTPUT_PIN) [*3]) else $error("compare pin moved between counts");
endmodule : tcc_sva

bind timer_capture_compare_unit tcc_sva #(.ADDR_WIDTH(ADDR_WIDTH)) chk_u (
  .I_CLK_SYS(I_CLK_SYS), .I_NRST(I_NRST), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
  .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA),
  .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .I_CAPTURE_INPUT_PIN(I_CAPTURE_INPUT_PIN),
  .I_COMPARATOR_TWO_FLAG(I_COMPARATOR_TWO_FLAG),
  .O_COMPARE_OUTPUT_PIN(O_COMPARE_OUTPUT_PIN), .O_TIMER_IRQ(O_TIMER_IRQ));

// ### test/tcc_far.sv
`timescale 1ns/1ps
// ****************************************************************
// Far side: capture pin and comparator flag sources.
// ****************************************************************
module tcc_far (
  input wire logic i_clk,
  output logic o_pin,
  output logic o_cmp
);
  initial begin
    o_pin = 1'b0;
    o_cmp = 1'b0;
  end
  // The wait after each change covers the pin synchroniser and capture update.
  task automatic drive(input logic pin, input logic cmp);
    @(posedge i_clk);
    o_pin <= pin;
    o_cmp <= cmp;
    repeat (6) @(posedge i_clk);
  endtask : drive
endmodule : tcc_far

// ### test/tb.sv
`timescale 1ns/1ps
// ****************************************************************
// Bench: APB master, read result queue and far-side model.
// ****************************************************************
module tb;
  localparam logic [7:0] CTL = 8'h48, FLG = 8'h4C, CPH = 8'h50, CPL = 8'h54, OCH = 8'h58;
  localparam logic [7:0] OCL = 8'h5C, TMH = 8'h60, TML = 8'h64, ANA = 8'h74;
  logic clk, nrst, psel, penable, pwrite, pready, pslverr, pin, cmp, pout, irq, frz_on;
  logic [7:0] paddr, frz, v, v3, rv;
  logic [31:0] pwdata, prdata;
  logic [7:0] q_e[$], q_m[$];
  logic [15:0] t;
  int fails, n_checks, n, ke, seed;
  timer_capture_compare_unit #(.ADDR_WIDTH(8)) dut_u (
    .I_CLK_SYS(clk), .I_NRST(nrst), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_CAPTURE_INPUT_PIN(pin), .I_COMPARATOR_TWO_FLAG(cmp),
    .O_COMPARE_OUTPUT_PIN(pout), .O_TIMER_IRQ(irq));
  tcc_far far_u (.i_clk(clk), .o_pin(pin), .o_cmp(cmp));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk or negedge nrst) n <= nrst ? n + 1 : 0;
  function automatic logic [15:0] cnt(input int k);
    return 16'hFFFC + 16'(k / 4);
  endfunction : cnt
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  // Requests avoid a counter tick between setup and access, so a counter
  // read has one expected value whichever of the two edges loads it.
  task automatic xfer(input logic w, input logic [7:0] a, d, e_in, m);
    logic [15:0] c;
    logic [7:0] e;
    @(posedge clk);
    while ((n + 2) % 4 == 0) @(posedge clk);
    c = cnt(n + 1);
    e = (a == TMH) ? c[15:8] : (a == TML) ? (frz_on ? frz : c[7:0]) : e_in;
    if (!w && a == TMH && !frz_on) frz = c[7:0];
    if (!w && (a == TMH || a == TML)) frz_on = (a == TMH);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    if (!w) q_e.push_back(e);
    if (!w) q_m.push_back(m);
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rv = prdata[7:0];
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic rd(input logic [7:0] a, e, m);
    xfer(1'b0, a, 8'h00, e, m);
  endtask : rd
  task automatic wr(input logic [7:0] a, d);
    xfer(1'b1, a, d, 8'h00, 8'h00);
  endtask : wr
  task automatic ocr(input logic [15:0] val);
    wr(OCH, val[15:8]);
    wr(OCL, val[7:0]);
  endtask : ocr
  task automatic till(input logic [15:0] val);
    while (cnt(n) !== val) @(posedge clk);
    repeat (3) @(posedge clk);
  endtask : till
  always @(posedge clk) begin
    if (psel && penable && !pwrite && pready) begin
      chk(prdata[7:0] & q_m[0], q_e[0] & q_m[0]);
      void'(q_e.pop_front());
      void'(q_m.pop_front());
    end
  end
  initial begin
    repeat (30000) @(posedge clk);
    fails++;
    summarize();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, nrst, frz_on} = '0;
    seed = 32'h1694;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    wr(FLG, 8'hFF);
    rd(FLG, 8'h00, 8'hE0);
    rd(CTL, 8'h00, 8'hFD);
    rd(TML, 8'h00, 8'hFF);
    rd(TMH, 8'h00, 8'hFF);
    repeat (9) @(posedge clk);
    rd(TML, 8'h00, 8'hFF);
    rd(FLG, 8'h20, 8'h20);
    rd(TML, 8'h00, 8'hFF);
    rd(FLG, 8'h00, 8'h20);
    // The power-up compare value matched at count zero; that flag is armed now.
    rd(OCL, 8'h00, 8'hFF);
    rd(FLG, 8'h00, 8'h40);
    rd(8'h00, 8'h00, 8'hFF);
    v = 8'($random(seed)) & 8'hE3;
    wr(CTL, v);
    rd(CTL, v, 8'hE3);
    chk(irq, 1'b0);
    t = cnt(n) + 16'h0014;
    wr(CTL, 8'h41);
    ocr(t);
    rd(OCH, t[15:8], 8'hFF);
    till(t + 16'h0001);
    chk(pout, 1'b1);
    chk(irq, 1'b1);
    wr(CTL, 8'h40);
    t = cnt(n) + 16'h000C;
    ocr(t);
    wr(OCH, t[15:8]);
    till(t + 16'h0002);
    chk(pout, 1'b1);
    t = cnt(n) + 16'h000C;
    ocr(t);
    till(t + 16'h0001);
    chk(pout, 1'b0);
    rd(FLG, 8'h40, 8'h40);
    rd(OCL, t[7:0], 8'hFF);
    rd(FLG, 8'h00, 8'h40);
    chk(irq, 1'b0);
    wr(CTL, 8'h02);
    ke = n;
    far_u.drive(1'b1, 1'b0);
    rd(FLG, 8'h80, 8'h80);
    rd(CPH, 8'h00, 8'h00);
    v = rv;
    rd(CPL, 8'h00, 8'h00);
    v3 = rv;
    chk(({v, v3} > cnt(ke)) && ({v, v3} <= cnt(ke + 8) + 16'h0001), 1'b1);
    rd(FLG, 8'h00, 8'h80);
    rd(CPH, v, 8'hFF);
    far_u.drive(1'b0, 1'b0);
    far_u.drive(1'b1, 1'b0);
    rd(FLG, 8'h00, 8'h80);
    rd(CPL, v3, 8'hFF);
    wr(CTL, 8'h00);
    far_u.drive(1'b0, 1'b0);
    rd(FLG, 8'h80, 8'h80);
    rd(CPL, 8'h00, 8'h00);
    wr(ANA, 8'h01);
    wr(CTL, 8'h82);
    far_u.drive(1'b1, 1'b0);
    rd(FLG, 8'h00, 8'h80);
    far_u.drive(1'b1, 1'b1);
    rd(CPH, 8'h00, 8'h00);
    v = rv;
    rd(CPL, 8'h00, 8'h00);
    v3 = rv;
    chk(irq, 1'b1);
    nrst <= 1'b0;
    frz_on = 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    chk(irq, 1'b0);
    rd(FLG, 8'h80, 8'hE0);
    rd(CTL, 8'h02, 8'hE3);
    rd(CPH, v, 8'hFF);
    rd(CPL, v3, 8'hFF);
    rd(OCL, t[7:0], 8'hFF);
    rd(TML, 8'h00, 8'hFF);
    summarize();
  end
endmodule : tb
